// [hw/arp_conv_core.sv]
// module: conversion timer producing a result after the conversion time
`timescale 1ns/1ps
module arp_conv_core (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [arp_pkg::RES_W-1:0] sample_in,
  arp_conv_if.core conv
);
  import arp_pkg::*;
  typedef struct packed {
    arp_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [RES_W-1:0] res;
  } arp_core_t;
  arp_core_t s_reg;
  arp_core_t s_next;
  logic [RES_W-1:0] held;
  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      ARP_IDLE: begin
        if (conv.start) begin
          s_next.st = ARP_CONV;
          s_next.cnt = CNT_ZERO;
        end
      end
      ARP_CONV: begin
        // further start requests ignored until done
        if (s_reg.cnt == CONV_LAST) begin
          s_next.st = ARP_LOAD;
          s_next.res = held;
        end else begin
          s_next.cnt = s_reg.cnt + 8'h01;
        end
      end
      ARP_LOAD: s_next.st = ARP_IDLE;
      default: s_next.st = ARP_IDLE;
    endcase
  end
  // sample held at the start instant
  logic [RES_W-1:0] held_reg;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_reg <= '{ARP_IDLE, CNT_ZERO, RES_RESET};
      held_reg <= RES_RESET;
    end else begin
      s_reg <= s_next;
      if (s_reg.st == ARP_IDLE && conv.start) held_reg <= sample_in;
    end
  end
  assign held = held_reg;
  // status stays active through the latch load cycle
  assign conv.busy = (s_reg.st != ARP_IDLE);
  assign conv.done = (s_reg.st == ARP_LOAD);
  assign conv.result = s_reg.res;
  a_busy_length: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $rose(s_reg.st == ARP_CONV) |-> (s_reg.st == ARP_CONV) [*8])
    else $error("conversion ended early");
  a_done_bound: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $rose(s_reg.st == ARP_CONV) |-> ##[1:130] (s_reg.st == ARP_LOAD))
    else $error("conversion did not finish in time");
endmodule : arp_conv_core

// [hw/arp_read_port.sv]
// module: read-ahead host read port of a 12-bit converter
// Operation
// - read-ahead read starts conversion, returns old word
// - next full read returns new word, restarts
// - first low-byte read starts, gives old low
// - high-byte read no start, msbs in lane
// - third low-byte read gives new low, restarts
// - msbs always on the upper four outputs
// - slow mode status holds host until done
// - high-byte read after slow conversion no wait
// - start and outputs lag strobe by clocks
// - start needs all three low, no restart
// - status low for whole conversion
// - status rises only after latches loaded
`timescale 1ns/1ps
module arp_read_port (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic byte_select_high_in,
  input wire logic [arp_pkg::RES_W-1:0] sample_in,
  output logic [arp_pkg::RES_W-1:0] data_output_pins_out,
  output logic [arp_pkg::RES_W-1:0] data_oe_n_out,
  output logic busy_n_out
);
  import arp_pkg::*;
  // status stays low for the count cycles, the last count and the load
  localparam logic [CNT_W-1:0] BUSY_SPAN = CONV_LAST + 8'h02;
  typedef struct packed {
    logic [1:0] cs_n_s;
    logic [1:0] rd_n_s;
    logic [1:0] hb_s;
    logic rd_act;
    logic oe;
    logic [RES_W-1:0] dout;
    logic [CNT_W-1:0] busy_cnt;
  } arp_port_t;
  arp_port_t s_reg;
  arp_port_t s_next;
  arp_conv_if conv ();
  arp_conv_core u_core (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .sample_in(sample_in),
    .conv(conv)
  );
  logic access;
  logic lowsel;
  logic [RES_W-1:0] word;
  always_comb begin
    s_next = s_reg;
    // two-stage synchronisers; only the second stage is read by logic
    s_next.cs_n_s = {s_reg.cs_n_s[0], cs_n_in};
    s_next.rd_n_s = {s_reg.rd_n_s[0], rd_n_in};
    s_next.hb_s = {s_reg.hb_s[0], byte_select_high_in};
    access = !s_reg.cs_n_s[1] && !s_reg.rd_n_s[1];
    lowsel = !s_reg.hb_s[1];
    s_next.rd_act = access;
    s_next.oe = access;
    // length of the current low status stretch, checked below
    if (conv.busy) begin
      s_next.busy_cnt = s_reg.busy_cnt + 8'h01;
    end else begin
      s_next.busy_cnt = CNT_ZERO;
    end
    word = conv.result;
    if (lowsel) begin
      s_next.dout = word;
    end else begin
      // msbs into the byte lane, upper lane nibble driven low
      s_next.dout = {word[RES_W-1 -: MSB_W], MSB_LOW,
                     word[RES_W-1 -: MSB_W]};
    end
  end
  // a conversion starts on the rising access edge with byte select low
  assign conv.start = access && !s_reg.rd_act && lowsel;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_reg <= '{2'b11, 2'b11, 2'b00, 1'b0, 1'b0, RES_RESET, CNT_ZERO};
    end else begin
      s_reg <= s_next;
    end
  end
  assign data_output_pins_out = s_reg.dout;
  // one enable per output pin, all from the same access flag
  for (genvar i = 0; i < RES_W; i++) begin : g_oe
    assign data_oe_n_out[i] = !s_reg.oe;
  end
  // low while converting; released only after the result latch loads
  assign busy_n_out = !conv.busy;
  a_start_gated: assert property (@(posedge clk_in) disable iff (!rstn_in)
    conv.start |-> (!s_reg.hb_s[1] && !s_reg.cs_n_s[1]
                    && !s_reg.rd_n_s[1]))
    else $error("conversion started without all selects low");
  a_no_hb_start: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (s_reg.hb_s[1] && !conv.busy) |=> !conv.busy)
    else $error("high byte read started a conversion");
  a_hb_lane: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (access && !lowsel) |=> (data_output_pins_out[7:4] == MSB_LOW
      && data_output_pins_out[3:0] == $past(conv.result[11:8])))
    else $error("high byte lane wrong");
  a_msb_upper: assert property (@(posedge clk_in) disable iff (!rstn_in)
    access |=> data_output_pins_out[11:8] == $past(conv.result[11:8]))
    else $error("upper outputs lost the msbs");
  a_old_word: assert property (@(posedge clk_in) disable iff (!rstn_in)
    conv.start |=> data_output_pins_out == $past(conv.result))
    else $error("read-ahead read did not show previous result");
  a_start_lag: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $fell(rd_n_in) && !cs_n_in && !byte_select_high_in && !conv.busy
    ##1 (!rd_n_in && !cs_n_in && !byte_select_high_in) [*3]
    |-> ##[0:2] conv.busy)
    else $error("start lagged the strobe too long");
  a_busy_until_load: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $rose(busy_n_out) |-> $past(conv.done))
    else $error("status released before latch load");
  a_oe_follow: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !access |=> data_oe_n_out[0])
    else $error("outputs driven outside an access");

  // start strobe and conversion entry
  a_start_once: assert property (@(posedge clk_in) disable iff (!rstn_in)
    conv.start
    |=> !conv.start)
    else $error("start strobe longer than one cycle");

  a_start_begins: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (conv.start && !conv.busy)
    |=> conv.busy)
    else $error("start from idle did not begin a conversion");

  a_busy_by_start: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $fell(busy_n_out)
    |-> $past(conv.start))
    else $error("status fell without a start");

  a_idle_quiet: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!conv.busy && !conv.start)
    |=> !conv.busy)
    else $error("conversion began without a start");

  a_no_restart: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (conv.start && conv.busy && !conv.done)
    |=> conv.busy)
    else $error("running conversion was restarted or cut");

  // status output
  a_busy_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (conv.busy && !conv.done)
    |=> conv.busy)
    else $error("status released in mid conversion");

  a_busy_cap: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_reg.busy_cnt <= BUSY_SPAN)
    else $error("status stayed low too long");

  a_busy_full: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $rose(busy_n_out)
    |-> s_reg.busy_cnt == BUSY_SPAN)
    else $error("status low for the wrong number of cycles");

  a_hb_no_wait: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (access && !lowsel && !conv.busy)
    |=> busy_n_out)
    else $error("high byte read requested a wait");

  // result latch and status release
  a_result_load: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $changed(conv.result)
    |-> conv.done)
    else $error("result latch changed outside the load cycle");

  a_done_pulse: assert property (@(posedge clk_in) disable iff (!rstn_in)
    conv.done
    |=> !conv.done)
    else $error("load cycle longer than one cycle");

  a_done_release: assert property (@(posedge clk_in) disable iff (!rstn_in)
    conv.done
    |=> busy_n_out)
    else $error("status not released after the load");

  // data lanes and enables
  a_low_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (access && lowsel)
    |=> data_output_pins_out == $past(conv.result))
    else $error("low byte read did not show the latched word");

  a_lane_match: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (access && !lowsel)
    |=> data_output_pins_out[11:8] == data_output_pins_out[3:0])
    else $error("byte lane and upper outputs disagree");

  a_oe_all_on: assert property (@(posedge clk_in) disable iff (!rstn_in)
    access
    |=> data_oe_n_out == {RES_W{1'b0}})
    else $error("outputs not driven during an access");

  a_oe_all_off: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !access
    |=> data_oe_n_out == {RES_W{1'b1}})
    else $error("some outputs driven outside an access");
endmodule : arp_read_port

// [include/arp_conv_if.sv]
// interface: start, status and result between port and converter core
`timescale 1ns/1ps
interface arp_conv_if;
  import arp_pkg::*;
  logic start;
  logic busy;
  logic done;
  logic [RES_W-1:0] result;
  modport port (output start, input busy, input done, input result);
  modport core (input start, output busy, output done, output result);
endinterface : arp_conv_if

// [include/arp_pkg.sv]
// package: constants and types for the adc read-ahead host read port
package arp_pkg;
  localparam int unsigned RES_W = 12;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned MSB_W = 4;
  localparam int unsigned CONV_NS = 3000;
  localparam int unsigned CLK_NS = 25;
  // conversion time is a least time: round up
  localparam int unsigned CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [RES_W-1:0] RES_RESET = 12'h000;
  localparam logic [MSB_W-1:0] MSB_LOW = 4'h0;
  typedef enum logic [1:0] {
    ARP_IDLE = 2'b00,
    ARP_CONV = 2'b01,
    ARP_LOAD = 2'b11
  } arp_state_t;
endpackage : arp_pkg

// [verif/arp_host_model.sv]
// host bus master model driving the read strobes
`timescale 1ns/1ps
module arp_host_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic hb_in,
  input wire logic slow_in,
  input wire logic busy_n_in,
  output logic cs_n_out,
  output logic rd_n_out,
  output logic byte_select_high_out
);
  logic act;
  // slow mode keeps the cycle open while status is low
  assign act = go_in || (slow_in && !busy_n_in && !cs_n_out);
  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    byte_select_high_out = 1'b0;
  end
  always @(posedge clk_in) begin
    cs_n_out <= !act;
    rd_n_out <= !act;
    byte_select_high_out <= hb_in;
  end
endmodule : arp_host_model

// [verif/tb_top.sv]
// self-checking bench for the read-ahead host read port
`timescale 1ns/1ps
module tb_top;
  import arp_pkg::*;
  logic clk_in, rstn_in, go, hb, slow, cs_n, rd_n, hbs, busy_n;
  logic [RES_W-1:0] sample, data, oe_n;
  int mismatches, comparisons, n;
  arp_host_model arp_host_model_inst (.clk_in(clk_in), .go_in(go),
    .hb_in(hb), .slow_in(slow), .busy_n_in(busy_n), .cs_n_out(cs_n),
    .rd_n_out(rd_n), .byte_select_high_out(hbs));
  arp_read_port arp_read_port_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .cs_n_in(cs_n), .rd_n_in(rd_n), .byte_select_high_in(hbs),
    .sample_in(sample), .data_output_pins_out(data),
    .data_oe_n_out(oe_n), .busy_n_out(busy_n));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [RES_W-1:0] e, g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [RES_W-1:0] hi(input logic [RES_W-1:0] r);
    return {r[11:8], 4'h0, r[11:8]};
  endfunction : hi
  task automatic acc(input logic h, input logic [RES_W-1:0] s, e,
      input logic b, input int gap);
    @(posedge clk_in);
    go <= 1'b1;
    hb <= h;
    sample <= s;
    repeat (7) @(posedge clk_in);
    #1;
    chk("data", e, data);
    chk("oe_n", 12'h000, oe_n);
    chk("busy_n", {11'h000, b}, {11'h000, busy_n});
    @(posedge clk_in);
    go <= 1'b0;
    repeat (gap) @(posedge clk_in);
  endtask : acc
  task automatic t_word;
    acc(1'b0, 12'ha5c, RES_RESET, 1'b0, 165);
    acc(1'b0, 12'h3e7, 12'ha5c, 1'b0, 165);
    $display("test word done");
  endtask : t_word
  task automatic t_byte;
    acc(1'b0, 12'hc18, 12'h3e7, 1'b0, 165);
    acc(1'b1, 12'h5b2, hi(12'hc18), 1'b1, 165);
    acc(1'b0, 12'h9f0, 12'hc18, 1'b0, 20);
    acc(1'b0, 12'h777, 12'hc18, 1'b0, 165);
    acc(1'b1, 12'h777, hi(12'h9f0), 1'b1, 20);
    $display("test byte done");
  endtask : t_byte
  task automatic t_slow;
    @(posedge clk_in);
    slow <= 1'b1;
    go <= 1'b1;
    hb <= 1'b0;
    sample <= 12'h6d4;
    repeat (7) @(posedge clk_in);
    go <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    chk("hold", 12'h000, {11'h000, cs_n});
    n = 0;
    while (busy_n !== 1'b1 && n < 300) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    #1;
    chk("busy_n", 12'h001, {11'h000, busy_n});
    @(posedge clk_in);
    slow <= 1'b0;
    #1;
    chk("data", 12'h6d4, data);
    repeat (40) @(posedge clk_in);
    acc(1'b1, 12'h111, hi(12'h6d4), 1'b1, 20);
    $display("test slow done");
  endtask : t_slow
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  initial begin
    rstn_in = 1'b0;
    go = 1'b0;
    hb = 1'b0;
    slow = 1'b0;
    sample = 12'h000;
    repeat (12) @(posedge clk_in);
    chk("oe_n", 12'hfff, oe_n);
    rstn_in <= 1'b1;
    t_word;
    t_byte;
    t_slow;
    end_of_test;
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    mismatches++;
    end_of_test;
  end
endmodule : tb_top
